/* src/adcrt_regs.sv */
// Result byte registers, trigger source selection and digital input disable registers
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module adcrt_regs (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [7:0]  i_wb_dat,
  input  wire logic [0:0]  i_wb_sel,
  output      logic [7:0]  o_wb_dat,
  output      logic        o_wb_ack,
  input  wire logic        i_conv_done,
  input  wire logic [9:0]  i_conv_result,
  input  wire logic        i_converter_enable,
  input  wire logic        i_auto_trigger_enable,
  input  wire logic        i_conversion_done_flag,
  input  wire logic        i_comparator_flag,
  input  wire logic        i_ext_int0_flag,
  input  wire logic        i_t0_cmp_a_flag,
  input  wire logic        i_t0_ovf_flag,
  input  wire logic        i_t1_cmp_b_flag,
  input  wire logic        i_t1_ovf_flag,
  input  wire logic        i_t1_capture_flag,
  input  wire logic [11:0] i_chan_pin_raw,
  input  wire logic [2:0]  i_aux_pin_raw,
  output      logic        o_auto_trigger_start,
  output      logic        o_result_updated,
  output      logic        o_left_adjust,
  output      logic        o_result_locked,
  output      logic [11:0] o_chan_input_off,
  output      logic [2:0]  o_aux_input_off,
  output      logic [11:0] o_chan_pin_in,
  output      logic [2:0]  o_aux_pin_in
);

  logic [9:0] result_q;
  logic       lock_q;
  logic [7:0] ctlb_q;
  logic [7:0] dis0_q;
  logic [7:0] dis1_q;
  logic [7:0] dis2_q;
  logic       trig_sel_q;
  logic       trig_sel_d;
  logic       start_q;
  logic       ack_q;
  logic [7:0] rdat_q;
  logic       acc;
  logic       wr;
  logic       rd_low;
  logic       rd_high;
  logic       wr_ctlb;
  logic       wr_dis0;
  logic       wr_dis1;
  logic       wr_dis2;
  logic       load;
  logic [7:0] res_low;
  logic [7:0] res_high;
  adcrt_pkg::adcrt_trig_t sel;

  // One-cycle answer; ack drops in the cycle after it was given
  assign acc     = i_wb_cyc && i_wb_stb && !ack_q;
  assign wr      = acc && i_wb_we && i_wb_sel[0];
  assign rd_low  = acc && !i_wb_we && (i_wb_adr == adcrt_pkg::ADDR_RESULT_LOW);
  assign rd_high = acc && !i_wb_we && (i_wb_adr == adcrt_pkg::ADDR_RESULT_HIGH);
  assign wr_ctlb = wr && (i_wb_adr == adcrt_pkg::ADDR_CONTROL_B);
  assign wr_dis0 = wr && (i_wb_adr == adcrt_pkg::ADDR_DISABLE_0);
  assign wr_dis1 = wr && (i_wb_adr == adcrt_pkg::ADDR_DISABLE_1);
  assign wr_dis2 = wr && (i_wb_adr == adcrt_pkg::ADDR_DISABLE_2);

  // Flag selected by the trigger code
  function automatic logic pick_flag(input adcrt_pkg::adcrt_trig_t code,
                                     input logic [6:0] flags);
    case (code)
      adcrt_pkg::TRIG_FREE_RUN:   pick_flag = 1'b0;
      adcrt_pkg::TRIG_COMPARATOR: pick_flag = flags[0];
      adcrt_pkg::TRIG_EXT_INT0:   pick_flag = flags[1];
      adcrt_pkg::TRIG_T0_CMP_A:   pick_flag = flags[2];
      adcrt_pkg::TRIG_T0_OVF:     pick_flag = flags[3];
      adcrt_pkg::TRIG_T1_CMP_B:   pick_flag = flags[4];
      adcrt_pkg::TRIG_T1_OVF:     pick_flag = flags[5];
      adcrt_pkg::TRIG_T1_CAPTURE: pick_flag = flags[6];
      default:                    pick_flag = 1'b0;
    endcase
  endfunction : pick_flag

  // Any address outside this set reads zero and ignores writes
  function automatic logic is_mapped(input logic [7:0] adr);
    case (adr)
      adcrt_pkg::ADDR_RESULT_LOW, adcrt_pkg::ADDR_RESULT_HIGH, adcrt_pkg::ADDR_CONTROL_B,
      adcrt_pkg::ADDR_DISABLE_0, adcrt_pkg::ADDR_DISABLE_1, adcrt_pkg::ADDR_DISABLE_2: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign sel = adcrt_pkg::adcrt_trig_t'(ctlb_q[adcrt_pkg::CTLB_TRIG_MSB:0]);

  // Free running is handled by the control side re-arming on the done flag; the level
  // here is held low so selecting it never makes a rising edge
  always_comb begin
    trig_sel_d = pick_flag(sel, {i_t1_capture_flag, i_t1_ovf_flag, i_t1_cmp_b_flag,
                                 i_t0_ovf_flag, i_t0_cmp_a_flag, i_ext_int0_flag,
                                 i_comparator_flag});
  end

  // Previous level tracks the currently selected source, so a switch from a clear
  // source to a set one shows up as a rising edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      trig_sel_q <= 1'b0;
    end else begin
      trig_sel_q <= trig_sel_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      start_q <= 1'b0;
    end else begin
      start_q <= i_auto_trigger_enable && i_converter_enable &&
                 trig_sel_d && !trig_sel_q;
    end
  end
  assign o_auto_trigger_start = start_q;

  // Lock takes effect on the low read; a done in the same cycle still loads
  assign load = i_conv_done && !lock_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      result_q <= adcrt_pkg::RESET_RESULT;
    end else if (load) begin
      result_q <= i_conv_result;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      lock_q <= 1'b0;
    end else if (rd_high) begin
      lock_q <= 1'b0;
    end else if (rd_low) begin
      lock_q <= 1'b1;
    end
  end

  // Updated pulse lines up with the new bytes being visible, for the done flag
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_result_updated <= 1'b0;
    end else begin
      o_result_updated <= load;
    end
  end

  // Presentation is combinational on the stored bit, so it follows a write at once
  always_comb begin
    if (ctlb_q[adcrt_pkg::CTLB_LEFT_ADJ]) begin
      res_high = result_q[9:2];
      res_low  = {result_q[1:0], 6'h00};
    end else begin
      res_high = {6'h00, result_q[9:8]};
      res_low  = result_q[7:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ctlb_q <= adcrt_pkg::RESET_BYTE;
    end else if (wr_ctlb) begin
      ctlb_q <= i_wb_dat & adcrt_pkg::CTLB_WR_MASK;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      dis0_q <= adcrt_pkg::RESET_BYTE;
    end else if (wr_dis0) begin
      dis0_q <= i_wb_dat;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      dis1_q <= adcrt_pkg::RESET_BYTE;
    end else if (wr_dis1) begin
      dis1_q <= i_wb_dat & adcrt_pkg::DIS1_WR_MASK;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      dis2_q <= adcrt_pkg::RESET_BYTE;
    end else if (wr_dis2) begin
      dis2_q <= i_wb_dat & adcrt_pkg::DIS2_WR_MASK;
    end
  end

  // Channel n disable bit: ch4..0 at dis0[7:3], ch8..5 at dis1[3:0], ch11..9 at dis2[2:0]
  assign o_chan_input_off = {dis2_q[2:0], dis1_q[3:0], dis0_q[7:3]};
  // Aux order: [2] comparator negative, [1] comparator positive, [0] reference pin
  assign o_aux_input_off  = dis0_q[2:0];
  assign o_left_adjust    = ctlb_q[adcrt_pkg::CTLB_LEFT_ADJ];
  assign o_result_locked  = lock_q;

  // Disabled buffers read zero at the port
  assign o_chan_pin_in = i_chan_pin_raw & ~o_chan_input_off;
  assign o_aux_pin_in  = i_aux_pin_raw & ~o_aux_input_off;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end
  assign o_wb_ack = ack_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rdat_q <= adcrt_pkg::READ_UNMAPPED;
    end else if (acc && !i_wb_we) begin
      case (i_wb_adr)
        adcrt_pkg::ADDR_RESULT_LOW:  rdat_q <= res_low;
        adcrt_pkg::ADDR_RESULT_HIGH: rdat_q <= res_high;
        adcrt_pkg::ADDR_CONTROL_B:   rdat_q <= ctlb_q;
        adcrt_pkg::ADDR_DISABLE_0:   rdat_q <= dis0_q;
        adcrt_pkg::ADDR_DISABLE_1:   rdat_q <= dis1_q;
        adcrt_pkg::ADDR_DISABLE_2:   rdat_q <= dis2_q;
        default:                     rdat_q <= adcrt_pkg::READ_UNMAPPED;
      endcase
    end
  end
  assign o_wb_dat = rdat_q;

  // Helper: marks a done that arrived while the result was locked, for coverage
  logic prev_done_locked_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      prev_done_locked_q <= 1'b0;
    end else begin
      prev_done_locked_q <= i_conv_done && lock_q;
    end
  end

  result_lock_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    lock_q && !rd_high |=> $stable(result_q))
    else $error("result changed while locked");

  result_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_conv_done && !lock_q |=> result_q == $past(i_conv_result) && o_result_updated)
    else $error("result not loaded on done");

  lock_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    rd_low && !rd_high |=> lock_q)
    else $error("low read did not lock");

  lock_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    rd_high |=> !lock_q)
    else $error("high read did not unlock");

  right_adj_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !o_left_adjust |-> res_high[7:2] == 6'h00 && {res_high[1:0], res_low} == result_q)
    else $error("right adjust layout wrong");

  left_adj_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_left_adjust |-> res_low[5:0] == 6'h00 && {res_high, res_low[7:6]} == result_q)
    else $error("left adjust layout wrong");

  adjust_now_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $changed(o_left_adjust) && result_q[9] |-> (res_high[7] == o_left_adjust))
    else $error("adjust change not immediate");

  auto_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_auto_trigger_enable || !i_converter_enable |=> !o_auto_trigger_start)
    else $error("start without auto trigger");

  trig_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_auto_trigger_start |-> $past(trig_sel_d) && !$past(trig_sel_q))
    else $error("start without rising edge");

  free_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    sel == adcrt_pkg::TRIG_FREE_RUN |=> !o_auto_trigger_start)
    else $error("free running made a trigger");

  reserved_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    ctlb_q[5:4] == 2'b00 && dis1_q[7:4] == 4'h0 && dis2_q[7:3] == 5'h00)
    else $error("reserved bits not zero");

  pin_force_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (o_chan_pin_in & o_chan_input_off) == 12'h000 && (o_aux_pin_in & o_aux_input_off) == 3'h0)
    else $error("disabled pin read nonzero");

  // Bus handshake: every request gets a one-cycle ack in the next cycle, and ack never comes without a request
  ack_answer_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not acknowledged");

  ack_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_wb_ack |=> !o_wb_ack)
    else $error("acknowledge held too long");

  ack_idle_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("acknowledge without request");

  rdat_keep_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !(acc && !i_wb_we) |=> $stable(o_wb_dat))
    else $error("read data moved without a read");

  rd_unmapped_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    acc && !i_wb_we && !is_mapped(i_wb_adr) |=> o_wb_dat == adcrt_pkg::READ_UNMAPPED)
    else $error("unmapped read not zero");

  lane_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    acc && i_wb_we && !i_wb_sel[0] |=>
      $stable(ctlb_q) && $stable(dis0_q) && $stable(dis1_q) && $stable(dis2_q))
    else $error("write with lane off changed a register");

  ctlb_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_ctlb |=> ctlb_q[7:6] == $past(i_wb_dat[7:6]) && ctlb_q[3:0] == $past(i_wb_dat[3:0]) &&
      ctlb_q[5:4] == 2'b00)
    else $error("control b write wrong");

  dis0_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_dis0 |=> dis0_q == $past(i_wb_dat))
    else $error("disable 0 write wrong");

  dis1_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_dis1 |=> dis1_q[3:0] == $past(i_wb_dat[3:0]))
    else $error("disable 1 write wrong");

  dis2_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wr_dis2 |=> dis2_q[2:0] == $past(i_wb_dat[2:0]))
    else $error("disable 2 write wrong");

  lock_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    lock_q && !rd_high |=> lock_q)
    else $error("lock dropped without high read");

  result_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_conv_done |=> $stable(result_q))
    else $error("result changed without done");

  updated_only_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_conv_done || lock_q |=> !o_result_updated)
    else $error("update pulse without load");

  low_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    rd_low && !o_left_adjust |=> o_wb_dat == $past(result_q[7:0]))
    else $error("right adjusted low read wrong");

  high_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    rd_high && o_left_adjust |=> o_wb_dat == $past(result_q[9:2]))
    else $error("left adjusted high read wrong");

  start_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_auto_trigger_start |=> !o_auto_trigger_start)
    else $error("start longer than one cycle");

  no_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !trig_sel_d || trig_sel_q |=> !o_auto_trigger_start)
    else $error("start without edge");

  switch_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $changed(sel) && trig_sel_d && !trig_sel_q && i_auto_trigger_enable && i_converter_enable |=>
      o_auto_trigger_start)
    else $error("switch to set source did not start");

  done_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    sel == adcrt_pkg::TRIG_FREE_RUN && i_conversion_done_flag |=> !o_auto_trigger_start)
    else $error("done flag made a trigger");

  pin_pass_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (o_chan_pin_in | o_chan_input_off) == (i_chan_pin_raw | o_chan_input_off) &&
      (o_aux_pin_in | o_aux_input_off) == (i_aux_pin_raw | o_aux_input_off))
    else $error("enabled pin not passed through");

  cov_locked_done_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) prev_done_locked_q);
  cov_auto_start_c:  cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_auto_trigger_start);
  cov_left_adj_c:    cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) rd_high && o_left_adjust);
  cov_switch_c:      cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $changed(sel) && trig_sel_d && !trig_sel_q);
  cov_lane_off_c:    cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) acc && i_wb_we && !i_wb_sel[0]);

endmodule : adcrt_regs

/* src/adcrt_pkg.sv */
// Constants, register map and types of the converter result and trigger register block
package adcrt_pkg;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h00;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h01;
  localparam logic [7:0] ADDR_CONTROL_B   = 8'h02;
  localparam logic [7:0] ADDR_DISABLE_0   = 8'h60;
  localparam logic [7:0] ADDR_DISABLE_1   = 8'h61;
  localparam logic [7:0] ADDR_DISABLE_2   = 8'h62;
  localparam int         CTLB_LEFT_ADJ    = 3;
  localparam int         CTLB_TRIG_MSB    = 2;
  localparam int         CTLB_TOUCH7      = 7;
  localparam int         CTLB_TOUCH6      = 6;
  localparam logic [7:0] CTLB_WR_MASK     = 8'hcf;
  localparam logic [7:0] DIS1_WR_MASK     = 8'h0f;
  localparam logic [7:0] DIS2_WR_MASK     = 8'h07;
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam logic [9:0] RESET_RESULT     = 10'h000;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;
  typedef enum logic [2:0] {
    TRIG_FREE_RUN   = 3'b000,
    TRIG_COMPARATOR = 3'b001,
    TRIG_EXT_INT0   = 3'b010,
    TRIG_T0_CMP_A   = 3'b011,
    TRIG_T0_OVF     = 3'b100,
    TRIG_T1_CMP_B   = 3'b101,
    TRIG_T1_OVF     = 3'b110,
    TRIG_T1_CAPTURE = 3'b111
  } adcrt_trig_t;
endpackage : adcrt_pkg

/* tb/adcrt_regs_bench.sv */
// Self-checking bench for the converter result, trigger and input disable registers
`timescale 1ns/1ps
module adcrt_regs_bench;
  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [0:0]  sel       = 1'b1;
  logic [7:0]  adr       = 8'h00;
  logic [7:0]  wdat      = 8'h00;
  logic        done      = 1'b0;
  logic [9:0]  result    = 10'h000;
  logic        conv_en   = 1'b1;
  logic        auto_en   = 1'b0;
  logic        done_flag = 1'b0;
  logic [6:0]  flags     = 7'h00;
  logic [11:0] chan_raw  = 12'h000;
  logic [2:0]  aux_raw   = 3'h0;
  logic [7:0]  o_dat, rdat, d0, d1, d2;
  logic        ack, start, updated, left_adj, locked;
  logic [11:0] chan_off, chan_in;
  logic [2:0]  aux_off, aux_in;
  logic [9:0]  r, r2;
  logic [7:0]  addrs [7] = '{8'h00, 8'h01, 8'h02, 8'h60, 8'h61, 8'h62, 8'h3c};
  integer      seed      = 32'h390ac44b;
  int          mismatches = 0, total_checks = 0, starts = 0, cycles = 0, s0;

  adcrt_regs dut_u (.i_clk_sys(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(o_dat), .o_wb_ack(ack),
    .i_conv_done(done), .i_conv_result(result), .i_converter_enable(conv_en),
    .i_auto_trigger_enable(auto_en), .i_conversion_done_flag(done_flag),
    .i_comparator_flag(flags[0]), .i_ext_int0_flag(flags[1]), .i_t0_cmp_a_flag(flags[2]),
    .i_t0_ovf_flag(flags[3]), .i_t1_cmp_b_flag(flags[4]), .i_t1_ovf_flag(flags[5]),
    .i_t1_capture_flag(flags[6]), .i_chan_pin_raw(chan_raw), .i_aux_pin_raw(aux_raw),
    .o_auto_trigger_start(start), .o_result_updated(updated), .o_left_adjust(left_adj),
    .o_result_locked(locked), .o_chan_input_off(chan_off), .o_aux_input_off(aux_off),
    .o_chan_pin_in(chan_in), .o_aux_pin_in(aux_in));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // Start pulses are counted here so trigger checks need no exact latency
  always @(posedge clk) begin
    cycles++;
    if (start === 1'b1) starts++;
    if (cycles == 20000) begin
      mismatches++;
      $display("Error at %0t: run did not finish in time", $time);
      results();
    end
  end

  function automatic logic [7:0] exp_low(input logic [9:0] v, input logic la);
    return la ? {v[1:0], 6'h00} : v[7:0];
  endfunction : exp_low

  function automatic logic [7:0] exp_high(input logic [9:0] v, input logic la);
    return la ? v[9:2] : {6'h00, v[9:8]};
  endfunction : exp_high

  task chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle: hold the request until ack is sampled high, then release
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    rdat = o_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(12'(n), 12'h002);
  endtask : wb

  task rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk({4'h0, rdat}, {4'h0, exp});
  endtask : rd

  task conv(input logic [9:0] v, input logic exp_upd);
    @(posedge clk);
    done <= 1'b1;
    result <= v;
    @(posedge clk);
    done <= 1'b0;
    result <= ~v;
    #1 chk({11'h000, updated}, {11'h000, exp_upd});
  endtask : conv

  task trig_cnt(input int exp);
    repeat (4) @(posedge clk);
    chk(12'(starts - s0), 12'(exp));
  endtask : trig_cnt

  task results;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    wb(1'b1, 8'h00, 8'ha5);
    wb(1'b1, 8'h3c, 8'hff);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    wb(1'b1, 8'h02, 8'h37);
    rd(8'h02, 8'h07);
    for (int k = 0; k < 4; k++) begin
      d0 = (k == 0) ? 8'hff : 8'($random(seed));
      d1 = (k == 0) ? 8'hff : 8'($random(seed));
      d2 = (k == 0) ? 8'hff : 8'($random(seed));
      wb(1'b1, 8'h60, d0);
      wb(1'b1, 8'h61, d1);
      wb(1'b1, 8'h62, d2);
      rd(8'h61, d1 & 8'h0f);
      rd(8'h62, d2 & 8'h07);
      rd(8'h60, d0);
      chan_raw <= 12'($random(seed));
      aux_raw <= 3'($random(seed));
      @(posedge clk);
      #1 chk(chan_off, {d2[2:0], d1[3:0], d0[7:3]});
      chk({9'h000, aux_off}, {9'h000, d0[2:0]});
      chk(chan_in, chan_raw & ~{d2[2:0], d1[3:0], d0[7:3]});
      chk({9'h000, aux_in}, {9'h000, aux_raw & ~d0[2:0]});
    end
    // A write with its byte lane off is acknowledged but stores nothing
    @(posedge clk);
    sel <= 1'b0;
    wb(1'b1, 8'h60, ~d0);
    sel <= 1'b1;
    rd(8'h60, d0);
    for (int k = 0; k < 4; k++) begin
      r = (k == 0) ? 10'h3ff : 10'($random(seed));
      wb(1'b1, 8'h02, {4'h0, k[0], 3'h0});
      conv(r, 1'b1);
      rd(8'h00, exp_low(r, k[0]));
      rd(8'h01, exp_high(r, k[0]));
      wb(1'b1, 8'h02, {4'h0, ~k[0], 3'h0});
      chk({11'h000, left_adj}, {11'h000, ~k[0]});
      rd(8'h01, exp_high(r, ~k[0]));
    end
    rd(8'h00, exp_low(r, 1'b0));
    chk({11'h000, locked}, 12'h001);
    r2 = r ^ 10'h2a5;
    conv(r2, 1'b0);
    rd(8'h01, exp_high(r, 1'b0));
    conv(r2, 1'b1);
    rd(8'h00, exp_low(r2, 1'b0));
    rd(8'h01, exp_high(r2, 1'b0));
    // Every source: other flags held high, only the selected one rises
    auto_en <= 1'b1;
    for (int c = 1; c < 8; c++) begin
      @(posedge clk);
      flags <= 7'h7f ^ (7'h01 << (c - 1));
      wb(1'b1, 8'h02, {5'h00, 3'(c)});
      s0 = starts;
      @(posedge clk);
      flags <= 7'h7f;
      trig_cnt(1);
    end
    flags <= 7'h7e;
    wb(1'b1, 8'h02, 8'h01);
    s0 = starts;
    wb(1'b1, 8'h02, 8'h02);
    trig_cnt(1);
    done_flag <= 1'b1;
    s0 = starts;
    wb(1'b1, 8'h02, 8'h00);
    trig_cnt(0);
    auto_en <= 1'b0;
    wb(1'b1, 8'h02, 8'h01);
    s0 = starts;
    flags <= 7'h7f;
    wb(1'b1, 8'h02, 8'h03);
    trig_cnt(0);
    // Converter off: a rising edge of the selected flag must not start
    conv_en <= 1'b0;
    auto_en <= 1'b1;
    flags <= 7'h7b;
    @(posedge clk);
    s0 = starts;
    flags <= 7'h7f;
    trig_cnt(0);
    // Reset in mid-run clears the stored result and the control bits
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    results();
  end
endmodule : adcrt_regs_bench
